// file: hdl/irq_enable_priority_unit.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1: Enable bit 7 is the global gate; zero masks all; resets to zero.
// RULE2: Enable bit 6 gates the converter request; resets to masked.
// RULE3: Serial request is transmit-done OR receive-done, gated by bit 4.
// RULE4: Enable bit 3 gates the Timer 1 overflow request; resets masked.
// RULE5: Enable bit 2 gates external interrupt 1; resets masked.
// RULE6: Enable bit 1 gates the Timer 0 overflow request; resets masked.
// RULE7: Enable bit 0 gates external interrupt 0; resets masked.
// RULE8: Enable bit 5 is reserved and never affects masking.
// RULE9: Each source has a level bit: zero low, one high.
// RULE10: Converter level bit chooses high or low; resets low.
// RULE11: Serial level bit chooses high or low; resets low.
// RULE12: Timer 1 level bit chooses high or low; resets low.
// RULE13: External 1 level bit chooses high or low; resets low.
// RULE14: Timer 0 level bit chooses high or low; resets low.
// RULE15: External 0 level bit chooses high or low; resets low.
// RULE16: Transmit-done flag set by hardware, cleared only by software.
// RULE17: Receive-done flag set by hardware, cleared only by software.
// RULE18: Ext 1 edge flag holds till cleared or serviced; level tracks pin.
// RULE19: Overflow sets each timer flag; software clears; flag forms request.
// RULE20: High requests preempt low routines; equal or lower levels wait.
module irq_enable_priority_unit
  import irq_pkg::*;
(
  input  wire logic          mclk,            // System clock, 10 MHz
  input  wire logic          reset_n,         // Asynchronous reset
  input  irq_pkg::sfr_req_t  sfr,             // Register bus request
  output logic      [7:0]    sfr_rdata,       // Register read data
  input  wire logic          ext0_irq_pin_n,  // External pin 0, async
  input  wire logic          ext1_irq_pin_n,  // External pin 1, async
  input  wire logic          timer0_overflow, // Timer 0 overflow pulse
  input  wire logic          timer1_overflow, // Timer 1 overflow pulse
  input  wire logic          tx_byte_done,    // Byte shifted out pulse
  input  wire logic          rx_byte_done,    // Byte received pulse
  input  wire logic          converter_irq,   // Converter request level
  input  wire logic          irq_ack,         // Core enters the routine
  input  wire logic          irq_return,      // Core leaves a routine
  output irq_pkg::irq_out_t  irq,             // Request to the core
  output logic      [1:0]    timer_run        // Timer run bits
);

  typedef struct packed {
    logic [7:0]  irq_enable_mask;
    logic [7:0]  irq_level_select;
    logic [7:0]  timer_ctrl;
    logic        tx_done_flag;
    logic        rx_done_flag;
    logic [1:0]  pin_prev;
    svc_state_t  svc;
    irq_out_t    out;
    logic [7:0]  rdata;
  } unit_state_t;

  unit_state_t        state;
  unit_state_t        next_state;
  logic [1:0]         pin_now;
  logic [1:0]         pin_fall;
  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] src_high;
  irq_out_t           pick;
  logic               wr_tctrl;
  logic               wr_serial;
  logic               wr_enable;
  logic               wr_level;
  logic               ack_ok;
  logic               ack_ext0;
  logic               ack_ext1;

  // Write strobe aimed at one register address
  function automatic logic wr_hit(input sfr_req_t r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // Bring both external pins into the clock domain
  pin_sync u_pin_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pin_in  ({ext1_irq_pin_n, ext0_irq_pin_n}),
    .pin_out (pin_now)
  );

  // Falling edge on an active-low pin marks a new request
  // History resets to idle high, so release of reset is no edge
  assign pin_fall = state.pin_prev & ~pin_now;

  // Register write decode
  assign wr_tctrl  = wr_hit(sfr, ADDR_TIMER_CTRL);
  assign wr_serial = wr_hit(sfr, ADDR_SERIAL_CTRL);
  assign wr_enable = wr_hit(sfr, ADDR_ENABLE);
  assign wr_level  = wr_hit(sfr, ADDR_LEVEL);

  // An acknowledge only counts while a request is presented
  // A stray acknowledge must not open a routine or clear a flag
  assign ack_ok   = irq_ack && state.out.req;
  assign ack_ext0 = ack_ok && (state.out.source == SRC_EXT0);
  assign ack_ext1 = ack_ok && (state.out.source == SRC_EXT1);

  // Raw requests in source order
  // The converter request is a level and is not latched here
  always_comb
  begin
    raw_req             = '0;
    raw_req[SRC_EXT0]   = state.timer_ctrl[TC_EXT0_FLAG];
    raw_req[SRC_TIMER0] = state.timer_ctrl[TC_T0_FLAG];        // RULE19
    raw_req[SRC_EXT1]   = state.timer_ctrl[TC_EXT1_FLAG];
    raw_req[SRC_TIMER1] = state.timer_ctrl[TC_T1_FLAG];        // RULE19
    raw_req[SRC_SERIAL] = state.tx_done_flag | state.rx_done_flag; // RULE3
    raw_req[SRC_ADC]    = converter_irq;
  end

  // Per-source and global gating; the reserved bit is not gathered
  // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
  assign pending = raw_req & src_bits(state.irq_enable_mask)
                 & {NUM_SRC{state.irq_enable_mask[BIT_GLOBAL]}}; // RULE1

  // Level of each source from its own bit
  // RULE10 RULE11 RULE12 RULE13 RULE14 RULE15
  assign src_high = src_bits(state.irq_level_select); // RULE9

  // Choose the request to present to the core
  // Lowest source number wins inside one level
  irq_arbiter u_arbiter (
    .pending (pending),
    .high    (src_high),
    .svc     (state.svc),
    .pick    (pick)
  );

  // Next state of the whole unit
  // Clears come before sets in each block, so a set wins the cycle
  always_comb
  begin
    next_state          = state;
    next_state.pin_prev = pin_now;

    // Enable and level registers; reserved bits stay zero
    if (wr_enable)
    begin
      next_state.irq_enable_mask = sfr.wdata & ENABLE_WMASK; // RULE8
    end
    if (wr_level)
    begin
      next_state.irq_level_select = sfr.wdata & LEVEL_WMASK; // RULE9
    end

    // Timer run bits and trigger selects are plain storage
    if (wr_tctrl)
    begin
      next_state.timer_ctrl[TC_T1_RUN]    = sfr.wdata[TC_T1_RUN];
      next_state.timer_ctrl[TC_T0_RUN]    = sfr.wdata[TC_T0_RUN];
      next_state.timer_ctrl[TC_EXT1_TRIG] = sfr.wdata[TC_EXT1_TRIG];
      next_state.timer_ctrl[TC_EXT0_TRIG] = sfr.wdata[TC_EXT0_TRIG];
    end

    // Timer overflow flags: software writes, overflow sets and wins
    if (wr_tctrl)
    begin
      next_state.timer_ctrl[TC_T1_FLAG] = sfr.wdata[TC_T1_FLAG];
      next_state.timer_ctrl[TC_T0_FLAG] = sfr.wdata[TC_T0_FLAG];
    end
    if (timer1_overflow)
    begin
      next_state.timer_ctrl[TC_T1_FLAG] = 1'b1; // RULE19
    end
    if (timer0_overflow)
    begin
      next_state.timer_ctrl[TC_T0_FLAG] = 1'b1; // RULE19
    end

    // External 1 flag: sticky on edges, follows the pin in level mode
    // In level mode a written flag value is ignored
    if (state.timer_ctrl[TC_EXT1_TRIG])
    begin
      if (wr_tctrl)
      begin
        next_state.timer_ctrl[TC_EXT1_FLAG] = sfr.wdata[TC_EXT1_FLAG];
      end
      if (ack_ext1)
      begin
        next_state.timer_ctrl[TC_EXT1_FLAG] = 1'b0; // RULE18
      end
      if (pin_fall[1])
      begin
        next_state.timer_ctrl[TC_EXT1_FLAG] = 1'b1; // RULE18
      end
    end
    else
    begin
      next_state.timer_ctrl[TC_EXT1_FLAG] = ~pin_now[1]; // RULE18
    end

    // External 0 flag behaves the same way with its own select
    if (state.timer_ctrl[TC_EXT0_TRIG])
    begin
      if (wr_tctrl)
      begin
        next_state.timer_ctrl[TC_EXT0_FLAG] = sfr.wdata[TC_EXT0_FLAG];
      end
      if (ack_ext0)
      begin
        next_state.timer_ctrl[TC_EXT0_FLAG] = 1'b0;
      end
      if (pin_fall[0])
      begin
        next_state.timer_ctrl[TC_EXT0_FLAG] = 1'b1;
      end
    end
    else
    begin
      next_state.timer_ctrl[TC_EXT0_FLAG] = ~pin_now[0];
    end

    // Serial flags: only software clears, a new byte wins the cycle
    if (wr_serial)
    begin
      next_state.tx_done_flag = sfr.wdata[SC_TX_DONE];
      next_state.rx_done_flag = sfr.wdata[SC_RX_DONE];
    end
    if (tx_byte_done)
    begin
      next_state.tx_done_flag = 1'b1; // RULE16
    end
    if (rx_byte_done)
    begin
      next_state.rx_done_flag = 1'b1; // RULE17
    end

    // Nesting of routines in service
    // Only one level of nesting: high may interrupt low, never high
    case (state.svc)
      SVC_NONE:
      begin
        if (ack_ok)
        begin
          next_state.svc = state.out.high ? SVC_HIGH : SVC_LOW;
        end
      end
      SVC_LOW:
      begin
        if (ack_ok && state.out.high)
        begin
          next_state.svc = SVC_HIGH_OVER_LOW; // RULE20
        end
        else if (irq_return)
        begin
          next_state.svc = SVC_NONE;
        end
      end
      SVC_HIGH:
      begin
        if (irq_return)
        begin
          next_state.svc = SVC_NONE;
        end
      end
      SVC_HIGH_OVER_LOW:
      begin
        if (irq_return)
        begin
          next_state.svc = SVC_LOW; // RULE20
        end
      end
      default:
      begin
        next_state.svc = SVC_NONE;
      end
    endcase

    // Drop the request for one cycle after an acknowledge or return
    // so the core never enters twice on a stale request
    if (ack_ok || irq_return)
    begin
      next_state.out = '{req: 1'b0, source: 3'h0, high: 1'b0};
    end
    else
    begin
      next_state.out = pick;
    end

    // Read data is captured on a read strobe; unmapped reads give zero
    // A read and a write in one cycle return the old value
    if (sfr.rd)
    begin
      case (sfr.addr)
        ADDR_TIMER_CTRL:
        begin
          next_state.rdata = state.timer_ctrl;
        end
        ADDR_SERIAL_CTRL:
        begin
          next_state.rdata = '0;
          next_state.rdata[SC_TX_DONE] = state.tx_done_flag;
          next_state.rdata[SC_RX_DONE] = state.rx_done_flag;
        end
        ADDR_ENABLE:
        begin
          next_state.rdata = state.irq_enable_mask;
        end
        ADDR_LEVEL:
        begin
          next_state.rdata = state.irq_level_select;
        end
        default:
        begin
          next_state.rdata = '0;
        end
      endcase
    end
  end

  // All registers of the unit
  // Reset gives masked sources, low levels and idle pin history
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state.irq_enable_mask  <= ENABLE_RESET; // RULE1
      state.irq_level_select <= LEVEL_RESET;
      state.timer_ctrl       <= TCTRL_RESET;
      state.tx_done_flag     <= SERIAL_RESET[SC_TX_DONE];
      state.rx_done_flag     <= SERIAL_RESET[SC_RX_DONE];
      state.pin_prev         <= PIN_IDLE;
      state.svc              <= SVC_NONE;
      state.out              <= '{req: 1'b0, source: 3'h0, high: 1'b0};
      state.rdata            <= 8'h00;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  // The request reaches the core one cycle after its flag
  assign sfr_rdata = state.rdata;
  assign irq       = state.out;
  assign timer_run = {state.timer_ctrl[TC_T1_RUN],
                      state.timer_ctrl[TC_T0_RUN]};

endmodule

// file: hdl/irq_pkg.sv
package irq_pkg;

  // Special function register addresses on the core's internal bus
  localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h88;
  localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
  localparam logic [7:0] ADDR_ENABLE      = 8'ha8;
  localparam logic [7:0] ADDR_LEVEL       = 8'hb8;

  // Enable register fields; the level register uses the same positions
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_ADC    = 6;
  localparam int BIT_RSVD   = 5;
  localparam int BIT_SERIAL = 4;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_EXT1   = 2;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_EXT0   = 0;

  // Timer control register fields
  localparam int TC_T1_FLAG   = 7;
  localparam int TC_T1_RUN    = 6;
  localparam int TC_T0_FLAG   = 5;
  localparam int TC_T0_RUN    = 4;
  localparam int TC_EXT1_FLAG = 3;
  localparam int TC_EXT1_TRIG = 2;
  localparam int TC_EXT0_FLAG = 1;
  localparam int TC_EXT0_TRIG = 0;

  // Serial control register fields
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;

  // Reset values and writable bits
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET  = 8'h00;
  localparam logic [7:0] TCTRL_RESET  = 8'h00;
  localparam logic [1:0] SERIAL_RESET = 2'h0;
  localparam logic [7:0] ENABLE_WMASK = 8'hdf;
  localparam logic [7:0] LEVEL_WMASK  = 8'h5f;
  localparam logic [1:0] PIN_IDLE     = 2'h3;

  // Source numbers, lowest number wins inside one level
  localparam int         NUM_SRC    = 6;
  localparam logic [2:0] SRC_EXT0   = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_EXT1   = 3'h2;
  localparam logic [2:0] SRC_TIMER1 = 3'h3;
  localparam logic [2:0] SRC_SERIAL = 3'h4;
  localparam logic [2:0] SRC_ADC    = 3'h5;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic       req;
    logic [2:0] source;
    logic       high;
  } irq_out_t;

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } pin_sync_t;

  typedef enum logic [1:0] {
    SVC_NONE,
    SVC_LOW,
    SVC_HIGH,
    SVC_HIGH_OVER_LOW
  } svc_state_t;

  // Gathers the per-source bits of enable or level register in source order
  function automatic logic [NUM_SRC-1:0] src_bits(input logic [7:0] r);
    src_bits = {r[BIT_ADC], r[BIT_SERIAL], r[BIT_TIMER1],
                r[BIT_EXT1], r[BIT_TIMER0], r[BIT_EXT0]};
  endfunction

endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync
  import irq_pkg::*;
(
  input  wire logic       mclk,    // System clock
  input  wire logic       reset_n, // Asynchronous reset, active low
  input  wire logic [1:0] pin_in,  // Asynchronous pin levels
  output logic      [1:0] pin_out  // Levels after two flip-flops
);

  pin_sync_t state;
  pin_sync_t next_state;

  // Second stage alone reads the first
  always_comb
  begin
    next_state.stage1 = pin_in;
    next_state.stage2 = state.stage1;
  end

  // Pins idle high, so reset to that level
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '{stage1: PIN_IDLE, stage2: PIN_IDLE};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign pin_out = state.stage2;

endmodule

// file: hdl/irq_arbiter.sv
`timescale 1ns/1ns
module irq_arbiter
  import irq_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] pending, // Enabled requests
  input  wire logic [NUM_SRC-1:0] high,    // Level of each source
  input  irq_pkg::svc_state_t     svc,     // Routines now in service
  output irq_pkg::irq_out_t       pick     // Winning request
);

  logic [NUM_SRC-1:0] hi_req;
  logic [NUM_SRC-1:0] lo_req;

  // High requests first, then low; fixed order inside a level
  always_comb
  begin
    hi_req = pending & high;
    lo_req = pending & ~high;
    pick   = '{req: 1'b0, source: 3'h0, high: 1'b0};
    if (svc == SVC_NONE)
    begin
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
        if (lo_req[i])
        begin
          pick = '{req: 1'b1, source: 3'(i), high: 1'b0};
        end
      end
    end
    // High level may preempt a low routine, never another high one
    if (svc == SVC_NONE || svc == SVC_LOW) // RULE20
    begin
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
        if (hi_req[i])
        begin
          pick = '{req: 1'b1, source: 3'(i), high: 1'b1};
        end
      end
    end
  end

endmodule

// file: tb/irq_monitor.sv
`timescale 1ns/1ns
module irq_monitor
  import irq_pkg::*;
(
  input  wire logic         mclk,            // System clock
  input  wire logic         reset_n,         // Reset, active low
  input  irq_pkg::sfr_req_t sfr,             // Register bus request
  input  wire logic [7:0]   sfr_rdata,       // Register read data
  input  wire logic         ext0_irq_pin_n,  // External pin 0
  input  wire logic         ext1_irq_pin_n,  // External pin 1
  input  wire logic         timer0_overflow, // Timer 0 pulse
  input  wire logic         timer1_overflow, // Timer 1 pulse
  input  wire logic         tx_byte_done,    // Transmit pulse
  input  wire logic         rx_byte_done,    // Receive pulse
  input  wire logic         converter_irq,   // Converter level
  input  wire logic         irq_ack,         // Routine entry
  input  wire logic         irq_return,      // Routine exit
  input  irq_pkg::irq_out_t irq,             // Request to the core
  input  wire logic [1:0]   timer_run        // Timer run bits
);
  logic [7:0] en_sh;
  logic [7:0] lv_sh;
  logic [7:0] en_d;
  logic [7:0] lv_d;
  logic       hi;
  logic       lo;

  // Enable bit position of a source number
  function automatic int pos(input logic [2:0] s);
    pos = (s == SRC_ADC) ? BIT_ADC : int'(s);
  endfunction

  // Mirror of both registers, delayed copy, and routines in service
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_sh <= 8'h00;
      lv_sh <= 8'h00;
      en_d  <= 8'h00;
      lv_d  <= 8'h00;
      hi    <= 1'b0;
      lo    <= 1'b0;
    end
    else
    begin
      en_d <= en_sh;
      lv_d <= lv_sh;
      if (sfr.wr && sfr.addr == ADDR_ENABLE)
        en_sh <= sfr.wdata & ENABLE_WMASK;
      if (sfr.wr && sfr.addr == ADDR_LEVEL)
        lv_sh <= sfr.wdata & LEVEL_WMASK;
      if (irq_ack && irq.req && irq.high)
        hi <= 1'b1;
      else if (irq_ack && irq.req)
        lo <= 1'b1;
      else if (irq_return && hi)
        hi <= 1'b0;
      else if (irq_return)
        lo <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_GLOBAL: assert property (irq.req |-> en_d[BIT_GLOBAL])
    else $error("request while global enable off");
  AST_SRC_EN: assert property (
    irq.req |-> en_d[pos(irq.source)])
    else $error("request from a masked source");
  AST_EN_READ: assert property (
    sfr.rd && sfr.addr == ADDR_ENABLE |=> sfr_rdata == en_d)
    else $error("enable readback wrong");
  AST_LV_READ: assert property (
    sfr.rd && sfr.addr == ADDR_LEVEL |=> sfr_rdata == lv_d)
    else $error("level readback wrong");
  AST_LEVEL: assert property (
    irq.req |-> irq.high == lv_d[pos(irq.source)])
    else $error("request level wrong");
  AST_ACK_GAP: assert property (irq_ack && irq.req |=> !irq.req)
    else $error("request not withdrawn after entry");
  AST_HIGH_BUSY: assert property (hi |-> !irq.req)
    else $error("request during high routine");
  AST_LOW_BUSY: assert property (lo && irq.req |-> irq.high)
    else $error("low request during low routine");
endmodule

bind irq_enable_priority_unit irq_monitor irq_monitor_inst (
  .mclk, .reset_n, .sfr, .sfr_rdata, .ext0_irq_pin_n, .ext1_irq_pin_n,
  .timer0_overflow, .timer1_overflow, .tx_byte_done, .rx_byte_done,
  .converter_irq, .irq_ack, .irq_return, .irq, .timer_run
);

// file: tb/core_model.sv
`timescale 1ns/1ns
module core_model
  import irq_pkg::*;
(
  input  wire logic         mclk,      // System clock
  input  wire logic         reset_n,   // Reset, active low
  input  irq_pkg::irq_out_t irq,       // Request from the unit
  input  wire logic         ack_en,    // Accept requests
  input  wire logic [3:0]   ack_wait,  // Cycles before entry
  input  wire logic         ret_req,   // Leave innermost routine
  output logic              irq_ack,   // Entry pulse
  output logic              irq_return // Exit pulse
);
  logic [3:0] waited;

  // Enters a routine after the chosen delay; returns when asked
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waited     <= 4'h0;
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
    end
    else
    begin
      irq_ack    <= 1'b0;
      irq_return <= ret_req;
      waited     <= 4'h0;
      if (irq.req && ack_en && !irq_ack && waited == ack_wait)
        irq_ack <= 1'b1;
      else if (irq.req && ack_en && !irq_ack)
        waited <= waited + 4'h1;
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import irq_pkg::*;
  logic         mclk;
  logic         reset_n;
  sfr_req_t     sfr;
  logic [7:0]   sfr_rdata;
  logic         ext0_irq_pin_n;
  logic         ext1_irq_pin_n;
  logic         timer0_overflow;
  logic         timer1_overflow;
  logic         tx_byte_done;
  logic         rx_byte_done;
  logic         converter_irq;
  logic         irq_ack;
  logic         irq_return;
  irq_out_t     irq;
  logic [1:0]   timer_run;
  logic         ack_en;
  logic [3:0]   ack_wait;
  logic         ret_req;
  int           num_errors;
  int           n_checks;

  irq_enable_priority_unit irq_enable_priority_unit_inst (
    .mclk, .reset_n, .sfr, .sfr_rdata, .ext0_irq_pin_n, .ext1_irq_pin_n,
    .timer0_overflow, .timer1_overflow, .tx_byte_done, .rx_byte_done,
    .converter_irq, .irq_ack, .irq_return, .irq, .timer_run
  );
  core_model core_model_inst (
    .mclk, .reset_n, .irq, .ack_en, .ack_wait, .ret_req, .irq_ack,
    .irq_return
  );

  // Free-running clock, 100 ns period
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge mclk);
    sfr.wr = 1'b0;
    @(negedge mclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge mclk);
    chk(sfr_rdata, exp);
    sfr.rd = 1'b0;
    @(negedge mclk);
  endtask

  // Waits for a request, then compares its source and level
  task automatic want(input logic [2:0] s, input logic h);
    int i;
    for (i = 0; i < 12 && irq.req !== 1'b1; i++)
      @(negedge mclk);
    if (i == 12)
    begin
      num_errors++;
      print_verdict();
    end
    else
      chk({3'h0, irq.req, irq.high, irq.source}, {3'h0, 1'b1, h, s});
  endtask

  task automatic no_req;
    chk({7'h0, irq.req}, 8'h00);
  endtask

  task automatic raise(input int i);
    case (i)
      0: ext0_irq_pin_n = 1'b0;
      1: timer0_overflow = 1'b1;
      2: ext1_irq_pin_n = 1'b0;
      3: timer1_overflow = 1'b1;
      4: tx_byte_done = 1'b1;
      5: converter_irq = 1'b1;
      default: rx_byte_done = 1'b1;
    endcase
    @(negedge mclk);
    timer0_overflow = 1'b0;
    timer1_overflow = 1'b0;
    tx_byte_done = 1'b0;
    rx_byte_done = 1'b0;
  endtask

  task automatic clear_all;
    ext0_irq_pin_n = 1'b1;
    ext1_irq_pin_n = 1'b1;
    converter_irq = 1'b0;
    wr(ADDR_TIMER_CTRL, 8'h00);
    wr(ADDR_SERIAL_CTRL, 8'h00);
    cyc(6);
  endtask

  // Reset values, reserved bits, unmapped place, timer run bits
  task automatic t_regs;
    rdchk(ADDR_ENABLE, 8'h00);
    rdchk(ADDR_LEVEL, 8'h00);
    rdchk(ADDR_TIMER_CTRL, 8'h00);
    rdchk(ADDR_SERIAL_CTRL, 8'h00);
    rdchk(8'h90, 8'h00);
    wr(ADDR_ENABLE, 8'hff);
    rdchk(ADDR_ENABLE, 8'hdf);
    wr(ADDR_LEVEL, 8'hff);
    rdchk(ADDR_LEVEL, 8'h5f);
    wr(8'h90, 8'h00);
    rdchk(ADDR_ENABLE, 8'hdf);
    wr(ADDR_TIMER_CTRL, 8'h50);
    chk({6'h0, timer_run}, 8'h03);
    clear_all();
    $display("t_regs done");
  endtask

  // Each source masked, then passed at its own level, then gated off
  task automatic t_sources;
    int i;
    int b;
    logic [7:0] lv;
    for (i = 0; i < 6; i++)
    begin
      b = (i == 5) ? BIT_ADC : i;
      lv = 8'h00;
      lv[b] = i[0];
      wr(ADDR_LEVEL, lv);
      wr(ADDR_ENABLE, 8'ha0);
      raise(i);
      cyc(6);
      no_req();
      wr(ADDR_ENABLE, 8'h80 | (8'h01 << b));
      want(i[2:0], i[0]);
      wr(ADDR_ENABLE, 8'h5f);
      cyc(2);
      no_req();
      clear_all();
    end
    $display("t_sources done");
  endtask

  // Serial request is the OR of two sticky flags
  task automatic t_serial;
    wr(ADDR_LEVEL, 8'h10);
    wr(ADDR_ENABLE, 8'h90);
    raise(6);
    want(SRC_SERIAL, 1'b1);
    cyc(10);
    rdchk(ADDR_SERIAL_CTRL, 8'h01);
    raise(4);
    rdchk(ADDR_SERIAL_CTRL, 8'h03);
    wr(ADDR_SERIAL_CTRL, 8'h02);
    rdchk(ADDR_SERIAL_CTRL, 8'h02);
    want(SRC_SERIAL, 1'b1);
    wr(ADDR_SERIAL_CTRL, 8'h00);
    cyc(3);
    no_req();
    $display("t_serial done");
  endtask

  // Low routine blocks its level; high preempts; none over high
  task automatic t_prio;
    ack_en = 1'b1;
    ack_wait = 4'h3;
    wr(ADDR_LEVEL, 8'h08);
    wr(ADDR_ENABLE, 8'h8a);
    raise(1);
    want(SRC_TIMER0, 1'b0);
    cyc(8);
    no_req();
    ack_wait = 4'h0;
    raise(3);
    want(SRC_TIMER1, 1'b1);
    cyc(4);
    no_req();
    rdchk(ADDR_TIMER_CTRL, 8'ha0);
    wr(ADDR_TIMER_CTRL, 8'h00);
    ret_req = 1'b1;
    cyc(1);
    ret_req = 1'b0;
    cyc(4);
    ret_req = 1'b1;
    cyc(1);
    ret_req = 1'b0;
    cyc(4);
    no_req();
    ack_en = 1'b0;
    $display("t_prio done");
  endtask

  // External 1 on edges: flag sticks after the pin returns, entry clears it
  task automatic t_edge;
    wr(ADDR_LEVEL, 8'h00);
    wr(ADDR_TIMER_CTRL, 8'h04);
    wr(ADDR_ENABLE, 8'h84);
    raise(2);
    ext1_irq_pin_n = 1'b1;
    cyc(6);
    want(SRC_EXT1, 1'b0);
    rdchk(ADDR_TIMER_CTRL, 8'h0c);
    ack_en = 1'b1;
    cyc(3);
    ack_en = 1'b0;
    rdchk(ADDR_TIMER_CTRL, 8'h04);
    ret_req = 1'b1;
    cyc(1);
    ret_req = 1'b0;
    cyc(3);
    no_req();
    wr(ADDR_TIMER_CTRL, 8'h00);
    $display("t_edge done");
  endtask

  // Main sequence
  initial
  begin
    num_errors = 0;
    n_checks = 0;
    reset_n = 1'b0;
    sfr = '0;
    ext0_irq_pin_n = 1'b1;
    ext1_irq_pin_n = 1'b1;
    timer0_overflow = 1'b0;
    timer1_overflow = 1'b0;
    tx_byte_done = 1'b0;
    rx_byte_done = 1'b0;
    converter_irq = 1'b0;
    ack_en = 1'b0;
    ack_wait = 4'h0;
    ret_req = 1'b0;
    cyc(6);
    reset_n = 1'b1;
    cyc(1);
    t_regs();
    t_sources();
    t_serial();
    t_prio();
    t_edge();
    print_verdict();
  end
endmodule
